// ### tec_pkg.sv
// Shared constants and types for the timer and event counter block
package tec_pkg;

	// Register map on the plain access port
	localparam logic [3:0] ADDR_T0CTL = 4'h0;
	localparam logic [3:0] ADDR_T0CNT = 4'h1;
	localparam logic [3:0] ADDR_T1CTL = 4'h2;
	localparam logic [3:0] ADDR_T1LO  = 4'h3;
	localparam logic [3:0] ADDR_T1HI  = 4'h4;
	localparam logic [3:0] ADDR_INTC  = 4'h5;

	// Control register fields
	localparam int MODE_HI  = 7;
	localparam int MODE_LO  = 6;
	localparam int RUN_BIT  = 4;
	localparam int EDGE_BIT = 3;

	// Interrupt control fields
	localparam int INTC_EN0 = 0;
	localparam int INTC_EN1 = 1;
	localparam int INTC_FL0 = 2;
	localparam int INTC_FL1 = 3;

	// Reset values
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [3:0] INTC_RESET = 4'h0;
	localparam logic [7:0] RD_IDLE    = 8'h00;

	// Internal clock is the system clock divided by this ratio
	localparam int          DIV_RATIO = 4;
	localparam logic [1:0]  DIV_LAST  = 2'(DIV_RATIO - 1);

	// Operating modes
	typedef enum logic [1:0] {
		MODE_OFF   = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_TIMER = 2'b10,
		MODE_PULSE = 2'b11
	} tec_mode_t;

	// Pulse width measurement sequence
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_MEAS = 4'b0100,
		ST_DONE = 4'b1000
	} tec_state_t;

endpackage

// ### tec_unit.sv
// One up-counter with preload, edge counting and pulse width sequence
`timescale 1ns/100ps
module tec_unit
	import tec_pkg::*;
#(
	parameter int W = 8	// Counter width
)(
	input  wire logic         clk,      // System clock
	input  wire logic         resetn,   // Async reset, active low
	input  wire tec_mode_t    mode,     // Operating mode
	input  wire logic         edge_sel, // Active edge select
	input  wire logic         run,      // Run enable
	input  wire logic         pin_lvl,  // Synchronised pin level
	input  wire logic         tick,     // Divided internal clock
	input  wire logic         pd,       // Power-down state
	input  wire logic         hold,     // Inhibit count this cycle
	input  wire logic         load_en,  // Preload write strobe
	input  wire logic [W-1:0] load_val, // Preload write value
	output logic      [W-1:0] count,    // Counter value
	output logic              ovf,      // Overflow pulse
	output logic              stop      // Auto stop pulse
);

	tec_state_t     state;
	tec_state_t     next_state;
	logic [W-1:0]   preload;
	logic [W-1:0]   next_count;
	logic           pin_last;
	logic           act_last;

	// Edge and level detection
	wire all_ones = &count;
	wire pin_act  = (pin_lvl == edge_sel);
	wire ev_edge  = edge_sel ? (pin_last & ~pin_lvl) : (~pin_last & pin_lvl);
	wire pw_start = tick & ~pd & ~act_last & pin_act & (state == ST_WAIT);
	wire pw_end   = tick & ~pin_act & (state == ST_MEAS);
	wire tm_inc   = (mode == MODE_TIMER) & tick & ~pd;
	wire ev_inc   = (mode == MODE_EVENT) & ev_edge;
	wire pw_inc   = (state == ST_MEAS) & tick & ~pd & pin_act;
	wire inc      = run & ~hold & (tm_inc | ev_inc | pw_inc);

	// Pulse width sequence
	always_comb begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (run && mode == MODE_PULSE)
				next_state = ST_WAIT;
		end
		ST_WAIT: begin
			if (!run || mode != MODE_PULSE)
				next_state = ST_IDLE;
			else if (pw_start)
				next_state = ST_MEAS;
		end
		ST_MEAS: begin
			if (!run || mode != MODE_PULSE)
				next_state = ST_IDLE;
			else if (pw_end)
				next_state = ST_DONE;
		end
		ST_DONE: begin
			if (!run)
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	// Counter value
	always_comb begin
		if (load_en && !run)
			next_count = load_val;
		else if (inc)
			next_count = all_ones ? preload : count + 1'b1;
		else
			next_count = count;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state    <= ST_IDLE;
			count    <= '0;
			preload  <= '0;
			ovf      <= 1'b0;
			stop     <= 1'b0;
			pin_last <= 1'b0;
			act_last <= 1'b0;
		end else begin
			state    <= next_state;
			count    <= next_count;
			preload  <= load_en ? load_val : preload;
			ovf      <= inc & all_ones;
			stop     <= pw_end & run;
			pin_last <= pin_lvl;
			if (tick)
				act_last <= pin_act;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_reload;
		inc && all_ones |=> count == $past(preload) && ovf;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on overflow");

	property p_hold;
		hold && run |=> count == $past(count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved during access");

	property p_done;
		state == ST_DONE && !load_en |=> count == $past(count);
	endproperty
	a_done: assert property (p_done) else $error("count moved after stop");

	property p_event;
		run && !hold && mode == MODE_EVENT && ev_edge && !all_ones
			|=> count == $past(count) + 1'b1;
	endproperty
	a_event: assert property (p_event) else $error("edge not counted");

	property p_run;
		!run && !load_en |=> $stable(count);
	endproperty
	a_run: assert property (p_run) else $error("count moved while off");

endmodule

// ### tec_top.sv
// Two timer and event counters with control, interrupt flags and wake-up
`timescale 1ns/100ps

// Overview of operation
// - Mode bits 7..6 equal to 10 select periodic timer mode.
// - Timer mode counts the system clock divided by four.
// - The counter runs only while run-enable bit 4 is high.
// - Overflow raises a request, reloads from preload and keeps counting.
// - Interrupt output is held off while its enable bit is zero.
// - Event mode counts pin transitions with no prescaler.
// - Edge select low counts rising edges, high counts falling edges.
// - Event counting continues in power-down; overflow then wakes.
// - Mode bits 11 select pulse width measurement.
// - Pulse mode counts divided clock after an active pin edge.
// - Edge select low: start on falling, stop on high, clear enable.
// - Edge select high: start on rising, stop on low, clear enable.
// - After auto stop, pin is ignored and count held until rearmed.
// - Outside pulse mode only software clears the enable bit.
// - Pin is synchronised; pulse edges act at the next timer tick.
// - Counter reads and preload writes inhibit counting that cycle.
// - Overflow always sets the flag; it wakes from power-down only while that flag is clear.
// - Pin must be an input for event and pulse use.
// - Preload goes to counter when stopped, else waits for overflow.
// - One eight-bit and one sixteen-bit up-counter.
// - Wide low byte is buffered; high byte access moves it.
module tec_top
	import tec_pkg::*;
(
	input  wire logic       clk,           // System clock
	input  wire logic       resetn,        // Async reset, active low
	input  wire logic [3:0] addr,          // Register address
	input  wire logic [7:0] wdata,         // Write data
	input  wire logic       wr,            // Write strobe
	input  wire logic       rd,            // Read strobe
	output logic      [7:0] rdata,         // Read data, cycle after rd
	input  wire logic       counter0_pin,  // External pin, counter 0
	input  wire logic       counter1_pin,  // External pin, counter 1
	input  wire logic       pin0_is_input, // Port control: pin 0 input
	input  wire logic       pin1_is_input, // Port control: pin 1 input
	input  wire logic       power_down,    // Device in power-down
	output logic            irq0,          // Counter 0 interrupt request
	output logic            irq1,          // Counter 1 interrupt request
	output logic            wake           // Wake-up pulse
);

	logic [7:0]  timer0_control;
	logic [7:0]  timer1_control;
	logic [3:0]  intc;
	logic [3:0]  next_intc;
	logic [7:0]  lo_buf;
	logic [1:0]  pin_meta;
	logic [1:0]  pin_sync;
	logic [1:0]  div_cnt;
	logic [7:0]  count0;
	logic [15:0] count1;
	logic        ovf0;
	logic        ovf1;
	logic        stop0;
	logic        stop1;

	// Address decode
	wire at_t0ctl = (addr == ADDR_T0CTL);
	wire at_t0cnt = (addr == ADDR_T0CNT);
	wire at_t1ctl = (addr == ADDR_T1CTL);
	wire at_t1lo  = (addr == ADDR_T1LO);
	wire at_t1hi  = (addr == ADDR_T1HI);
	wire at_intc  = (addr == ADDR_INTC);

	wire wr_t0ctl = wr & at_t0ctl;
	wire wr_t0cnt = wr & at_t0cnt;
	wire wr_t1ctl = wr & at_t1ctl;
	wire wr_t1lo  = wr & at_t1lo;
	wire wr_t1hi  = wr & at_t1hi;
	wire wr_intc  = wr & at_intc;
	wire rd_t1hi  = rd & at_t1hi;

	// Mode and field decode
	wire tec_mode_t mode0 = tec_mode_t'(timer0_control[MODE_HI:MODE_LO]);
	wire tec_mode_t mode1 = tec_mode_t'(timer1_control[MODE_HI:MODE_LO]);
	wire run0  = timer0_control[RUN_BIT];
	wire run1  = timer1_control[RUN_BIT];
	wire edge0 = timer0_control[EDGE_BIT];
	wire edge1 = timer1_control[EDGE_BIT];

	// Off mode stops the counter; pin modes need the pin set as input
	wire pin_ok0 = (mode0 == MODE_TIMER) | pin0_is_input;
	wire pin_ok1 = (mode1 == MODE_TIMER) | pin1_is_input;
	wire run_eff0 = run0 & (mode0 != MODE_OFF) & pin_ok0;
	wire run_eff1 = run1 & (mode1 != MODE_OFF) & pin_ok1;

	// Access inhibits for counter reads and preload writes
	wire hold0 = (rd | wr) & at_t0cnt;
	wire hold1 = rd & (at_t1lo | at_t1hi) | wr_t1hi;

	// Auto stop clears run only while the unit is still in pulse mode
	wire clr_run0 = stop0 & (mode0 == MODE_PULSE);
	wire clr_run1 = stop1 & (mode1 == MODE_PULSE);

	// Internal clock, one tick every fourth system clock
	wire tick = (div_cnt == DIV_LAST);

	// Read mux
	wire [7:0] intc_view = {4'h0, intc};
	wire [7:0] rd_mux =
		at_t0ctl ? timer0_control :
		at_t0cnt ? count0 :
		at_t1ctl ? timer1_control :
		at_t1lo  ? lo_buf :
		at_t1hi  ? count1[15:8] :
		at_intc  ? intc_view : RD_IDLE;

	// Two-stage synchroniser for both pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
		end else begin
			pin_meta <= {counter1_pin, counter0_pin};
			pin_sync <= pin_meta;
		end
	end

	// Divider for the internal clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			div_cnt <= 2'h0;
		else
			div_cnt <= div_cnt + 2'h1;
	end

	// Counter 0 control; only pulse mode clears run by itself
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer0_control <= CTL_RESET;
		end else if (wr_t0ctl) begin
			timer0_control <= wdata;
		end else if (clr_run0) begin
			timer0_control[RUN_BIT] <= 1'b0;
		end
	end

	// Counter 1 control
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer1_control <= CTL_RESET;
		end else if (wr_t1ctl) begin
			timer1_control <= wdata;
		end else if (clr_run1) begin
			timer1_control[RUN_BIT] <= 1'b0;
		end
	end

	// Low byte buffer of the wide counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lo_buf <= 8'h00;
		end else if (wr_t1lo) begin
			lo_buf <= wdata;
		end else if (rd_t1hi) begin
			lo_buf <= count1[7:0];
		end
	end

	// Interrupt enables and flags; an overflow wins over a clear
	always_comb begin
		next_intc = intc;
		if (wr_intc)
			next_intc = wdata[3:0];
		if (ovf0)
			next_intc[INTC_FL0] = 1'b1;
		if (ovf1)
			next_intc[INTC_FL1] = 1'b1;
	end

	// Flags, gated requests and wake-up
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			intc <= INTC_RESET;
			irq0 <= 1'b0;
			irq1 <= 1'b0;
			wake <= 1'b0;
		end else begin
			intc <= next_intc;
			irq0 <= next_intc[INTC_FL0] & next_intc[INTC_EN0];
			irq1 <= next_intc[INTC_FL1] & next_intc[INTC_EN1];
			wake <= power_down & (ovf0 & ~intc[INTC_FL0] |
				ovf1 & ~intc[INTC_FL1]);
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata <= RD_IDLE;
		else
			rdata <= rd ? rd_mux : RD_IDLE;
	end

	// Eight-bit counter
	tec_unit #(
		.W        (8)
	) u_cnt0 (
		.clk      (clk),
		.resetn   (resetn),
		.mode     (mode0),
		.edge_sel (edge0),
		.run      (run_eff0),
		.pin_lvl  (pin_sync[0]),
		.tick     (tick),
		.pd       (power_down),
		.hold     (hold0),
		.load_en  (wr_t0cnt),
		.load_val (wdata),
		.count    (count0),
		.ovf      (ovf0),
		.stop     (stop0)
	);

	// Sixteen-bit counter, loaded as a whole on the high byte write
	tec_unit #(
		.W        (16)
	) u_cnt1 (
		.clk      (clk),
		.resetn   (resetn),
		.mode     (mode1),
		.edge_sel (edge1),
		.run      (run_eff1),
		.pin_lvl  (pin_sync[1]),
		.tick     (tick),
		.pd       (power_down),
		.hold     (hold1),
		.load_en  (wr_t1hi),
		.load_val ({wdata, lo_buf}),
		.count    (count1),
		.ovf      (ovf1),
		.stop     (stop1)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_irq_gate;
		irq0 |-> intc[INTC_EN0] && intc[INTC_FL0];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request not masked");

	property p_flag_set;
		ovf0 |=> intc[INTC_FL0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");

	property p_wake;
		ovf1 && power_down && !intc[INTC_FL1] |=> wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake-up");

	property p_autostop;
		stop0 && !wr_t0ctl && mode0 == MODE_PULSE |=> !timer0_control[RUN_BIT];
	endproperty
	a_autostop: assert property (p_autostop) else $error("enable not cleared");

	property p_keep_run;
		run1 && mode1 != MODE_PULSE && !wr_t1ctl |=> run1;
	endproperty
	a_keep_run: assert property (p_keep_run) else $error("enable lost");

	property p_lo_latch;
		rd_t1hi && !wr_t1lo |=> lo_buf == $past(count1[7:0]);
	endproperty
	a_lo_latch: assert property (p_lo_latch) else $error("low byte not latched");

	property p_tick_rate;
		tick |=> !tick ##1 !tick ##1 !tick ##1 tick;
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("tick rate wrong");

	property p_rd_once;
		!rd |=> rdata == RD_IDLE;
	endproperty
	a_rd_once: assert property (p_rd_once) else $error("read data held");

	property p_flag1_set;
		ovf1 |=> intc[INTC_FL1];
	endproperty
	a_flag1_set: assert property (p_flag1_set) else $error("flag1 lost");

	property p_wake0;
		ovf0 && power_down && !intc[INTC_FL0] |=> wake;
	endproperty
	a_wake0: assert property (p_wake0) else $error("no wake-up from counter 0");

	property p_no_wake;
		!power_down |=> !wake;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake-up while awake");

	property p_wake_src;
		wake |-> $past(ovf0) || $past(ovf1);
	endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake-up without overflow");

	property p_autostop1;
		stop1 && !wr_t1ctl && mode1 == MODE_PULSE |=> !timer1_control[RUN_BIT];
	endproperty
	a_autostop1: assert property (p_autostop1) else $error("enable 1 not cleared");

	property p_keep_run0;
		run0 && mode0 != MODE_PULSE && !wr_t0ctl |=> run0;
	endproperty
	a_keep_run0: assert property (p_keep_run0) else $error("enable 0 lost");

	property p_ctl_write;
		wr_t0ctl |=> timer0_control == $past(wdata);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

	property p_flag_clear;
		wr_intc && !wdata[INTC_FL0] && !ovf0 |=> !intc[INTC_FL0];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag0 not cleared");

	property p_rd_ctl;
		rd && at_t0ctl |=> rdata == $past(timer0_control);
	endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");

	property p_lo_write;
		wr_t1lo |=> lo_buf == $past(wdata);
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("low byte not buffered");

	property p_wide_load;
		wr_t1hi && !run_eff1 |=> count1 == {$past(wdata), $past(lo_buf)};
	endproperty
	a_wide_load: assert property (p_wide_load) else $error("wide load wrong");

	property p_hold1;
		hold1 && run_eff1 |=> $stable(count1);
	endproperty
	a_hold1: assert property (p_hold1) else $error("wide count moved on access");

	property p_pin_off;
		!pin0_is_input && mode0 == MODE_EVENT && !wr_t0cnt |=> $stable(count0);
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("counted on output pin");

endmodule

// ### tec_pin_src.sv
// External pulse and event source that drives one timer pin
`timescale 1ns/100ps
module tec_pin_src (
	input  wire logic clk, // System clock
	output logic      pin  // Timer pin level
);
	// Pin is a plain input with a defined level at all times
	initial pin = 1'b0;

	// Sets the resting level between pulses
	task automatic idle(input logic lvl);
		@(posedge clk);
		pin <= lvl;
	endtask

	// One pulse away from the resting level; phases last several clocks
	// so the synchroniser always sees both edges
	task automatic pulse(input int act, input int rest);
		@(posedge clk);
		pin <= ~pin;
		repeat (act) @(posedge clk);
		pin <= ~pin;
		repeat (rest) @(posedge clk);
	endtask
endmodule

// ### timer_event_counter_modes_tb.sv
// Self-checking bench for the timer and event counter block
`timescale 1ns/100ps
module timer_event_counter_modes_tb
	import tec_pkg::*;
;
	logic       clk    = 1'b0;
	logic       resetn = 1'b0;
	logic [3:0] addr   = 4'h0;
	logic [7:0] wdata  = 8'h00;
	logic       wr     = 1'b0;
	logic       rd     = 1'b0;
	logic       in0    = 1'b1; // Pin 0 is an input
	logic       in1    = 1'b1; // Pin 1 is an input
	logic       pdown  = 1'b0;
	logic [7:0] rdata;
	logic       pin0;
	logic       pin1;
	logic       irq0;
	logic       irq1;
	logic       wake;
	logic [7:0] v;
	logic [7:0] a;
	logic [7:0] b;
	int         fails  = 0;
	int         checks = 0;
	int         wakes  = 0;
	int         n;

	// 100 MHz system clock
	always #5 clk = ~clk;

	tec_top dut (
		.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
		.counter0_pin(pin0), .counter1_pin(pin1),
		.pin0_is_input(in0), .pin1_is_input(in1),
		.power_down(pdown), .irq0, .irq1, .wake
	);
	tec_pin_src src0 (.clk, .pin(pin0));
	tec_pin_src src1 (.clk, .pin(pin1));

	// Counts wake-up pulses midway through each cycle, where they stand settled
	always @(negedge clk) begin
		if (wake === 1'b1) begin
			wakes++;
		end
	end

	// Control byte from mode, run and edge select
	function automatic logic [7:0] ctl(input logic [1:0] m, input logic r, input logic e);
		return {m, 1'b0, r, e, 3'b000};
	endfunction

	// One when a value lies inside a window
	function automatic logic [7:0] in_range(input logic [7:0] x, lo, hi);
		return {7'h0, (x >= lo) && (x <= hi)};
	endfunction

	task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic expect_reg(input string what, input logic [3:0] ad, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(ad, d);
		check(what, d, exp);
	endtask

	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict;
	end

	initial begin
		void'($urandom(55));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		// Reset values, storage bits and an unmapped place
		expect_reg("ctl0 reset", ADDR_T0CTL, CTL_RESET);
		expect_reg("ctl1 reset", ADDR_T1CTL, CTL_RESET);
		expect_reg("intc reset", ADDR_INTC, 8'h00);
		wr_reg(4'h7, 8'h5a);
		expect_reg("unmapped", 4'h6, 8'h00);
		wr_reg(ADDR_T0CTL, 8'h2f);
		expect_reg("ctl0 storage", ADDR_T0CTL, 8'h2f);
		wr_reg(ADDR_T0CTL, 8'h3f);
		repeat (20) @(posedge clk);
		expect_reg("off mode held", ADDR_T0CNT, 8'h00);
		$display("test registers done");
		// Timer rate and run enable; mode set first, count loaded before run
		wr_reg(ADDR_T0CTL, ctl(2'b10, 0, 0));
		wr_reg(ADDR_T0CNT, 8'h00);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 1, 0));
		repeat (40) @(posedge clk);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 0, 0));
		rd_reg(ADDR_T0CNT, v);
		check("timer rate", in_range(v, 8'd9, 8'd12), 8'h01);
		repeat (20) @(posedge clk);
		expect_reg("timer held", ADDR_T0CNT, v);
		$display("test timer done");
		// Overflow, reload, flag and mask
		wr_reg(ADDR_T0CNT, 8'hfc);
		wr_reg(ADDR_INTC, 8'h01);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 1, 0));
		repeat (40) @(posedge clk);
		check("irq0 on", {7'h0, irq0}, 8'h01);
		expect_reg("run kept", ADDR_T0CTL, ctl(2'b10, 1, 0));
		rd_reg(ADDR_T0CNT, v);
		check("reloaded", in_range(v, 8'hfc, 8'hff), 8'h01);
		expect_reg("intc flag0", ADDR_INTC, 8'h05);
		wr_reg(ADDR_INTC, 8'h00);
		repeat (40) @(posedge clk);
		check("irq0 masked", {7'h0, irq0}, 8'h00);
		expect_reg("flag0 again", ADDR_INTC, 8'h04);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 0, 0));
		// Preload written while running must not reach the counter
		wr_reg(ADDR_T0CNT, 8'h00);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 1, 0));
		wr_reg(ADDR_T0CNT, 8'h80);
		rd_reg(ADDR_T0CNT, v);
		check("preload waits", in_range(v, 8'h00, 8'h04), 8'h01);
		wr_reg(ADDR_T0CTL, ctl(2'b10, 0, 0));
		$display("test overflow done");
		// Random event trains on both edge selections
		for (int e = 0; e < 2; e++) begin
			src0.idle(1'b0);
			wr_reg(ADDR_T0CTL, ctl(2'b01, 0, e[0]));
			wr_reg(ADDR_T0CNT, 8'h00);
			wr_reg(ADDR_T0CTL, ctl(2'b01, 1, e[0]));
			n = 1 + $urandom % 20;
			repeat (n) src0.pulse(3 + $urandom % 4, 3 + $urandom % 4);
			repeat (4) @(posedge clk);
			expect_reg("event count", ADDR_T0CNT, 8'(n));
		end
		// Pin set as output: edges must not count
		src0.idle(1'b0);
		in0 <= 1'b0;
		src0.pulse(4, 8);
		in0 <= 1'b1;
		expect_reg("pin not input", ADDR_T0CNT, 8'(n));
		$display("test events done");
		// Event overflow in power-down wakes once, then a set flag blocks it
		wr_reg(ADDR_T0CTL, ctl(2'b01, 0, 0));
		wr_reg(ADDR_T0CNT, 8'hff);
		wr_reg(ADDR_INTC, 8'h00);
		pdown <= 1'b1;
		wr_reg(ADDR_T0CTL, ctl(2'b01, 1, 0));
		src0.pulse(4, 8);
		check("wake once", 8'(wakes), 8'h01);
		expect_reg("flag0 pd", ADDR_INTC, 8'h04);
		src0.pulse(4, 8);
		check("wake blocked", 8'(wakes), 8'h01);
		pdown <= 1'b0;
		$display("test power-down done");
		// Pulse width, both polarities, then pin ignored after auto stop
		for (int e = 0; e < 2; e++) begin
			src0.idle(!e[0]);
			wr_reg(ADDR_T0CTL, ctl(2'b11, 0, e[0]));
			wr_reg(ADDR_T0CNT, 8'h00);
			wr_reg(ADDR_T0CTL, ctl(2'b11, 1, e[0]));
			n = 3 + $urandom % 10;
			repeat (8) @(posedge clk);
			src0.pulse(4 * n, 16);
			expect_reg("auto stop", ADDR_T0CTL, ctl(2'b11, 0, e[0]));
			rd_reg(ADDR_T0CNT, v);
			check("width", in_range(v, 8'(n - 2), 8'(n + 1)), 8'h01);
			src0.pulse(4 * n, 16);
			expect_reg("held", ADDR_T0CNT, v);
		end
		$display("test pulse width done");
		// Wide counter byte pairing and overflow by one event
		a = 8'($urandom);
		b = 8'($urandom);
		wr_reg(ADDR_T1LO, a);
		wr_reg(ADDR_T1HI, b);
		expect_reg("wide high", ADDR_T1HI, b);
		expect_reg("wide low", ADDR_T1LO, a);
		wr_reg(ADDR_T1LO, 8'hff);
		wr_reg(ADDR_T1HI, 8'hff);
		wr_reg(ADDR_INTC, 8'h02);
		wr_reg(ADDR_T1CTL, ctl(2'b01, 0, 0));
		wr_reg(ADDR_T1CTL, ctl(2'b01, 1, 0));
		src1.pulse(4, 8);
		check("irq1 on", {7'h0, irq1}, 8'h01);
		expect_reg("intc flag1", ADDR_INTC, 8'h0a);
		expect_reg("wide reload", ADDR_T1HI, 8'hff);
		$display("test wide counter done");
		give_verdict;
	end
endmodule
